// *** verilog/out_router_pkg.sv ***
// package: register map, source codes and carriers for the output router
package out_router_pkg;

	localparam int unsigned NUM_OUTPUTS = 3;
	localparam int unsigned SEL_W       = 4;
	localparam int unsigned ADDR_W      = 12;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_SELECT   = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_POLARITY = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_LEVEL    = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_SOURCES  = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_OUTPUTS  = 12'h010;

	// select field of output n sits at bits [SEL_STRIDE*n +: SEL_W]
	localparam int unsigned SEL_STRIDE = 8;

	localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;

	// source codes
	typedef enum logic [SEL_W-1:0] {
		SRC_SOFTWARE    = 4'h0,
		SRC_ACQ_READY   = 4'h1,
		SRC_TRIG_READY  = 4'h2,
		SRC_FRAME_START = 4'h3,
		SRC_EXPOSING    = 4'h4,
		SRC_READOUT     = 4'h5,
		SRC_IMAGING     = 4'h6,
		SRC_ACQUIRING   = 4'h7,
		SRC_LINE_ONE    = 4'h8,
		SRC_LINE_TWO    = 4'h9,
		SRC_PULSE_ONE   = 4'ha,
		SRC_CC1         = 4'hb,
		SRC_CC2         = 4'hc,
		SRC_CC3         = 4'hd,
		SRC_CC4         = 4'he
	} source_sel_t;

	localparam int unsigned NUM_SOURCES = 15;

	// camera status inputs
	typedef struct packed {
		logic       acq_ready;
		logic       trig_ready;
		logic       frame_start;
		logic       exposing;
		logic       readout;
		logic       acquiring;
		logic       line_one;
		logic       line_two;
		logic       pulse_one;
		logic [3:0] cc_trig;
	} cam_status_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

endpackage : out_router_pkg

// *** verilog/camera_output_signal_router.sv ***
// camera output router: per-line source mux, polarity and apb registers
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module camera_output_signal_router #(
	parameter int unsigned N_OUT = out_router_pkg::NUM_OUTPUTS
) (
	input  wire logic                             clk,
	input  wire logic                             rst_b,
	input  wire out_router_pkg::cam_status_t      status,
	input  wire out_router_pkg::apb_req_t         apb_req,
	output var  out_router_pkg::apb_rsp_t         apb_rsp,
	output logic [N_OUT-1:0]                      line_out
);

	localparam int unsigned SW  = out_router_pkg::SEL_W;
	localparam int unsigned NS  = out_router_pkg::NUM_SOURCES;

	logic [N_OUT-1:0][SW-1:0] select_q;
	logic [N_OUT-1:0]         polarity_q;
	logic [N_OUT-1:0]         level_q;
	logic [NS-1:0]            src_vec;
	logic [N_OUT-1:0]         mux_out;
	logic                     access;
	logic [31:0]              sel_word;

	// packed source vector, index equals source code
	always_comb begin
		src_vec = '0;
		src_vec[out_router_pkg::SRC_SOFTWARE]    = 1'b0;
		src_vec[out_router_pkg::SRC_ACQ_READY]   = status.acq_ready;
		src_vec[out_router_pkg::SRC_TRIG_READY]  = status.trig_ready;
		src_vec[out_router_pkg::SRC_FRAME_START] = status.frame_start;
		src_vec[out_router_pkg::SRC_EXPOSING]    = status.exposing;
		src_vec[out_router_pkg::SRC_READOUT]     = status.readout;
		src_vec[out_router_pkg::SRC_IMAGING]     =
			status.exposing | status.readout;
		src_vec[out_router_pkg::SRC_ACQUIRING]   = status.acquiring;
		src_vec[out_router_pkg::SRC_LINE_ONE]    = status.line_one;
		src_vec[out_router_pkg::SRC_LINE_TWO]    = status.line_two;
		src_vec[out_router_pkg::SRC_PULSE_ONE]   = status.pulse_one;
		src_vec[out_router_pkg::SRC_CC1]         = status.cc_trig[0];
		src_vec[out_router_pkg::SRC_CC2]         = status.cc_trig[1];
		src_vec[out_router_pkg::SRC_CC3]         = status.cc_trig[2];
		src_vec[out_router_pkg::SRC_CC4]         = status.cc_trig[3];
	end

	// select one source; unused codes give low
	function automatic logic pick(input logic [SW-1:0] sel,
			input logic [NS-1:0] srcs, input logic sw_level);
		logic r;
		r = 1'b0;
		if (sel == out_router_pkg::SRC_SOFTWARE) begin
			r = sw_level;
		end else if (sel < SW'(NS)) begin
			r = srcs[sel];
		end
		return r;
	endfunction : pick

	// true for the five register offsets
	function automatic logic is_mapped(
			input logic [out_router_pkg::ADDR_W-1:0] a);
		return a == out_router_pkg::OFS_SELECT ||
			a == out_router_pkg::OFS_POLARITY ||
			a == out_router_pkg::OFS_LEVEL ||
			a == out_router_pkg::OFS_SOURCES ||
			a == out_router_pkg::OFS_OUTPUTS;
	endfunction : is_mapped

	genvar g;
	generate
		for (g = 0; g < N_OUT; g++) begin : g_line
			assign mux_out[g] = pick(select_q[g], src_vec, level_q[g]);

			// polarity applied after the mux
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					line_out[g] <= 1'b0;
				end else begin
					line_out[g] <= mux_out[g] ^ polarity_q[g];
				end
			end

			assign sel_word[out_router_pkg::SEL_STRIDE*g +: SW] = select_q[g];
			assign sel_word[out_router_pkg::SEL_STRIDE*g+SW +:
				out_router_pkg::SEL_STRIDE-SW] = '0;
		end
	endgenerate
	assign sel_word[31:out_router_pkg::SEL_STRIDE*N_OUT] = '0;

	assign access = apb_req.psel & apb_req.penable;

	// select fields, one per line
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < N_OUT; i++) begin
				select_q[i] <= out_router_pkg::SEL_RESET;
			end
		end else if (access && apb_req.pwrite &&
				apb_req.paddr == out_router_pkg::OFS_SELECT) begin
			for (int i = 0; i < N_OUT; i++) begin
				select_q[i] <= apb_req.pwdata[out_router_pkg::SEL_STRIDE*i +: SW];
			end
		end
	end

	// polarity bits
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			polarity_q <= '0;
		end else if (access && apb_req.pwrite &&
				apb_req.paddr == out_router_pkg::OFS_POLARITY) begin
			polarity_q <= apb_req.pwdata[N_OUT-1:0];
		end
	end

	// software output levels
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			level_q <= '0;
		end else if (access && apb_req.pwrite &&
				apb_req.paddr == out_router_pkg::OFS_LEVEL) begin
			level_q <= apb_req.pwdata[N_OUT-1:0];
		end
	end

	// apb answer: zero wait states, error on unmapped address
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp.pready  <= apb_req.psel & ~apb_req.penable;
			apb_rsp.pslverr <= 1'b0;
			apb_rsp.prdata  <= '0;
			if (apb_req.psel && !apb_req.penable) begin
				if (apb_req.paddr == out_router_pkg::OFS_SELECT) begin
					apb_rsp.prdata <= sel_word;
				end else if (apb_req.paddr == out_router_pkg::OFS_POLARITY) begin
					apb_rsp.prdata <= 32'(polarity_q);
				end else if (apb_req.paddr == out_router_pkg::OFS_LEVEL) begin
					apb_rsp.prdata <= 32'(level_q);
				end else if (apb_req.paddr == out_router_pkg::OFS_SOURCES) begin
					apb_rsp.prdata <= 32'(src_vec);
				end else if (apb_req.paddr == out_router_pkg::OFS_OUTPUTS) begin
					apb_rsp.prdata <= 32'(line_out);
				end else begin
					apb_rsp.pslverr <= 1'b1;
				end
			end
		end
	end

	// selected source, inverted by polarity, shows one cycle later
	a_line_follows: assert property (
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> line_out == ($past(mux_out) ^ $past(polarity_q)))
		else $error("line output does not follow mux and polarity");

	a_polarity_inverts: assert property (
		@(posedge clk) disable iff (!rst_b)
		$changed(polarity_q[0]) && $stable(mux_out[0]) |=>
			line_out[0] != $past(line_out[0]))
		else $error("polarity change not applied");

	a_sw_level: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[0] == out_router_pkg::SRC_SOFTWARE |=>
			line_out[0] == ($past(level_q[0]) ^ $past(polarity_q[0])))
		else $error("software level not driven");

	a_imaging_or: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[0] == out_router_pkg::SRC_IMAGING && !polarity_q[0] |=>
			line_out[0] == ($past(status.exposing) | $past(status.readout)))
		else $error("imaging is not exposing or readout");

	a_exposing_route: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[1] == out_router_pkg::SRC_EXPOSING && polarity_q[1] |=>
			line_out[1] == ~$past(status.exposing))
		else $error("exposure source not routed inverted");

	a_cc_route: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[0] == out_router_pkg::SRC_CC4 && !polarity_q[0] |=>
			line_out[0] == $past(status.cc_trig[3]))
		else $error("control line four not routed");

	a_line_in_route: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[2] == out_router_pkg::SRC_LINE_TWO && !polarity_q[2] |=>
			line_out[2] == $past(status.line_two))
		else $error("input line two not relayed");

	a_select_write: assert property (
		@(posedge clk) disable iff (!rst_b)
		access && apb_req.pwrite &&
			apb_req.paddr == out_router_pkg::OFS_SELECT |=>
			select_q[1] ==
				$past(apb_req.pwdata[out_router_pkg::SEL_STRIDE +: SW]))
		else $error("select field write lost");

	a_pulse_route: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[1] == out_router_pkg::SRC_PULSE_ONE && !polarity_q[1] |=>
			line_out[1] == $past(status.pulse_one))
		else $error("pulse generator not routed");

	// one routing check per remaining source, on varied lines
	a_acq_route: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[2] == out_router_pkg::SRC_ACQ_READY && !polarity_q[2] |=>
			line_out[2] == $past(status.acq_ready))
		else $error("acquisition ready not routed");

	a_trig_ready_route: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[2] == out_router_pkg::SRC_TRIG_READY && !polarity_q[2] |=>
			line_out[2] == $past(status.trig_ready))
		else $error("trigger ready not routed");

	a_frame_start_route: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[0] == out_router_pkg::SRC_FRAME_START && !polarity_q[0] |=>
			line_out[0] == $past(status.frame_start))
		else $error("frame start not routed");

	a_readout_route: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[1] == out_router_pkg::SRC_READOUT && !polarity_q[1] |=>
			line_out[1] == $past(status.readout))
		else $error("readout not routed");

	a_acquiring_route: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[2] == out_router_pkg::SRC_ACQUIRING && !polarity_q[2] |=>
			line_out[2] == $past(status.acquiring))
		else $error("acquiring not routed");

	a_line_one_route: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[0] == out_router_pkg::SRC_LINE_ONE && !polarity_q[0] |=>
			line_out[0] == $past(status.line_one))
		else $error("input line one not relayed");

	a_cc_one_route: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[1] == out_router_pkg::SRC_CC1 && !polarity_q[1] |=>
			line_out[1] == $past(status.cc_trig[0]))
		else $error("control line one not routed");

	a_cc_two_route: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[2] == out_router_pkg::SRC_CC2 && !polarity_q[2] |=>
			line_out[2] == $past(status.cc_trig[1]))
		else $error("control line two not routed");

	a_cc_three_route: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[1] == out_router_pkg::SRC_CC3 && !polarity_q[1] |=>
			line_out[1] == $past(status.cc_trig[2]))
		else $error("control line three not routed");

	// unused code drives low before polarity
	a_unused_low: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[0] == SW'(NS) && !polarity_q[0] |=> !line_out[0])
		else $error("unused select code not low");

	a_lines_independent: assert property (
		@(posedge clk) disable iff (!rst_b)
		select_q[2] == out_router_pkg::SRC_SOFTWARE |=>
			line_out[2] == ($past(level_q[2]) ^ $past(polarity_q[2])))
		else $error("line two software level not independent");

	a_polarity_write: assert property (
		@(posedge clk) disable iff (!rst_b)
		access && apb_req.pwrite &&
			apb_req.paddr == out_router_pkg::OFS_POLARITY |=>
			polarity_q == $past(apb_req.pwdata[N_OUT-1:0]))
		else $error("polarity write lost");

	a_level_write: assert property (
		@(posedge clk) disable iff (!rst_b)
		access && apb_req.pwrite &&
			apb_req.paddr == out_router_pkg::OFS_LEVEL |=>
			level_q == $past(apb_req.pwdata[N_OUT-1:0]))
		else $error("level write lost");

	a_pready_setup: assert property (
		@(posedge clk) disable iff (!rst_b)
		apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
		else $error("no ready in access cycle");

	a_unmapped_err: assert property (
		@(posedge clk) disable iff (!rst_b)
		apb_req.psel && !apb_req.penable && !is_mapped(apb_req.paddr) |=>
			apb_rsp.pslverr)
		else $error("unmapped access without error");

	a_mapped_no_err: assert property (
		@(posedge clk) disable iff (!rst_b)
		apb_req.psel && !apb_req.penable && is_mapped(apb_req.paddr) |=>
			!apb_rsp.pslverr)
		else $error("mapped access flagged as error");

endmodule : camera_output_signal_router

`default_nettype wire

// *** verification/out_line_observer.sv ***
// far-side equipment model: counts rising edges on output line zero
`timescale 1ns/100ps
`default_nettype none
module out_line_observer (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [2:0] line_out,
	output logic [7:0]      rise_cnt
);
	logic prev_q;

	// reacts to rising edges only, the fast direction
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_q   <= 1'b0;
			rise_cnt <= 8'h00;
		end else begin
			prev_q <= line_out[0];
			if (line_out[0] && !prev_q)
				rise_cnt <= rise_cnt + 8'h01;
		end
	end
endmodule : out_line_observer
`default_nettype wire

// *** verification/camera_output_signal_router_tb_top.sv ***
// testbench for the camera output router
`timescale 1ns/100ps
`default_nettype none
module camera_output_signal_router_tb_top;
	logic                        clk;
	logic                        rst_b;
	out_router_pkg::cam_status_t status;
	out_router_pkg::apb_req_t    apb_req;
	out_router_pkg::apb_rsp_t    apb_rsp;
	logic [2:0]                  line_out;
	logic [7:0]                  rise_cnt;
	logic [31:0]                 rd;
	logic [31:0]                 sel;
	logic                        err;
	int                          bad_count = 0;
	int                          n_tests = 0;
	int                          cyc = 0;

	camera_output_signal_router #(.N_OUT(3)) i_dut (.clk(clk),
		.rst_b(rst_b), .status(status), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .line_out(line_out));
	out_line_observer i_far (.clk(clk), .rst_b(rst_b),
		.line_out(line_out), .rise_cnt(rise_cnt));

	// status vector with one status bit set to drive the given source (imaging is also active for codes 4 and 5)
	function automatic logic [12:0] stat_for(input int code);
		if (code <= 5) return 13'h1 << (13 - code);
		if (code == 6) return 13'h1 << 9;
		if (code <= 10) return 13'h1 << (14 - code);
		return 13'h1 << (code - 11);
	endfunction : stat_for

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		apb_req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 16);
		chk("pready", 32'h1, {31'h0, apb_rsp.pready});
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
	endtask : apb

	task automatic chk_line(input string nm, input logic [2:0] e);
		repeat (2) @(posedge clk);
		#1;
		chk(nm, {29'h0, e}, {29'h0, line_out});
	endtask : chk_line

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			complete_run();
		end
	end

	initial begin
		rst_b = 1'b0;
		status = '0;
		apb_req = '0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, out_router_pkg::OFS_SELECT, 32'h0);
		chk("select", 32'h0, rd);
		apb(1'b0, out_router_pkg::OFS_POLARITY, 32'h0);
		chk("polarity", 32'h0, rd);
		$display("reset test done");
		apb(1'b1, out_router_pkg::OFS_LEVEL, 32'h5);
		chk_line("sw level", 3'h5);
		apb(1'b1, out_router_pkg::OFS_POLARITY, 32'h3);
		chk_line("inverted", 3'h6);
		chk("rises", 32'h1, {24'h0, rise_cnt});
		apb(1'b1, out_router_pkg::OFS_OUTPUTS, 32'h0);
		chk("ro err", 32'h0, {31'h0, err});
		apb(1'b0, out_router_pkg::OFS_OUTPUTS, 32'h0);
		chk("out reg", 32'h6, rd);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'b1, out_router_pkg::OFS_SELECT, 32'h000f0f0f);
		apb(1'b1, out_router_pkg::OFS_POLARITY, 32'h7);
		chk_line("mux then inv", 3'h7);
		apb(1'b1, out_router_pkg::OFS_POLARITY, 32'h0);
		$display("software test done");
		for (int n = 0; n < 3; n++) begin
			for (int k = 1; k < 15; k++) begin
				sel = 32'h000f0f0f;
				sel[8*n +: 4] = 4'(k);
				apb(1'b1, out_router_pkg::OFS_SELECT, sel);
				status <= out_router_pkg::cam_status_t'(stat_for(k));
				chk_line("src on", 3'(1 << n));
				apb(1'b0, out_router_pkg::OFS_SOURCES, 32'h0);
				chk("src bit", 32'h1, {31'h0, rd[k]});
				@(posedge clk);
				status <= '0;
				chk_line("src off", 3'h0);
			end
		end
		apb(1'b1, out_router_pkg::OFS_SELECT, 32'h000f0f06);
		status <= out_router_pkg::cam_status_t'(13'h1 << 8);
		chk_line("imaging", 3'h1);
		apb(1'b1, out_router_pkg::OFS_SELECT, 32'h000f040f);
		apb(1'b1, out_router_pkg::OFS_POLARITY, 32'h2);
		status <= out_router_pkg::cam_status_t'(13'h1 << 9);
		chk_line("exp inv on", 3'h0);
		@(posedge clk);
		status <= '0;
		chk_line("exp inv off", 3'h2);
		$display("mux test done");
		complete_run();
	end
endmodule : camera_output_signal_router_tb_top
`default_nettype wire
